/* design/sap_port.sv */
`timescale 1ns/1ps
// Summary of operation
// - every comreset or comwake holds exactly six bursts unless a new request restarts it mid-train; retries hold six too
// - receiver recognises oob after four consecutive bursts, three gaps
// - set device bits fis with n set and wrong pmp is dropped
// - soft reset during dma setup reception requests sync escape of next data
// - phy loss during non-data fis never sets recovered integrity error
// - phy loss during non-data fis sets interface non-fatal status
// - global host reset clears every pending port bit in global status
// - interrupt driven only while global enable set; no stale after reset
module sap_port
   import sap_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // link side
   input  wire logic        phy_rdy,
   input  wire logic        oob_rx_burst,
   output logic             oob_tx_burst,
   input  wire logic        rx_fis_start,
   input  wire logic [7:0]  rx_fis_type,
   input  wire logic        rx_fis_nbit,
   input  wire logic [3:0]  rx_fis_pmp,
   input  wire logic        rx_fis_end,
   output logic             rx_fis_store,
   output logic             tx_sync_esc,
   input  wire logic        tx_xrdycoll,
   input  wire logic        link_esc_done,
   output logic             irq
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic phy_rdy_s;
   logic oob_rx_s;

   sap_sync3 u_sync_phy (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (phy_rdy),
      .q       (phy_rdy_s)
   );

   sap_sync3 u_sync_oob (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (oob_rx_burst),
      .q       (oob_rx_s)
   );

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [1:0]       ghc_q;
   logic             gis_q;
   logic [PIS_W-1:0] pis_q;
   logic [PIS_W-1:0] pie_q;
   logic             serr_q;
   logic [3:0]       pmp_q;
   logic [7:0]       awaddr_q;
   logic [31:0]      wdata_q;
   logic             aw_have_q;
   logic             w_have_q;
   sap_tstate_type   tst_q;
   sap_ostate_type   ost_q;

   // write fires once both halves are held and no response is pending
   wire        wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
   wire        wr_ghc   = wr_fire && (awaddr_q == GHC_OFF);
   wire        wr_pis   = wr_fire && (awaddr_q == PIS_OFF);
   wire        wr_pie   = wr_fire && (awaddr_q == PIE_OFF);
   wire        wr_serr  = wr_fire && (awaddr_q == SERR_OFF);
   wire        wr_pcmd  = wr_fire && (awaddr_q == PCMD_OFF);
   wire        wr_pmp   = wr_fire && (awaddr_q == PMP_OFF);
   wire        wr_known = wr_ghc || wr_pis || wr_pie || wr_serr || wr_pcmd || wr_pmp
                          || (awaddr_q == GIS_OFF) || (awaddr_q == PSTAT_OFF);
   wire        host_rst = wr_ghc && wdata_q[GHC_HR_BIT];
   wire        cmd_rst  = wr_pcmd && wdata_q[CMD_RST_BIT];
   wire        cmd_wake = wr_pcmd && wdata_q[CMD_WAKE_BIT];
   wire        cmd_srst = wr_pcmd && wdata_q[CMD_SRST_BIT];
   wire        rd_fire  = s_axi_arvalid && s_axi_arready;

   // read mux by if/else-if decode
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      if (s_axi_araddr == GHC_OFF) begin
         rd_val = {30'h0, ghc_q};
      end else if (s_axi_araddr == GIS_OFF) begin
         rd_val = {31'h0, gis_q};
      end else if (s_axi_araddr == PIS_OFF) begin
         rd_val = {28'h0, pis_q};
      end else if (s_axi_araddr == PIE_OFF) begin
         rd_val = {28'h0, pie_q};
      end else if (s_axi_araddr == SERR_OFF) begin
         rd_val = {31'h0, serr_q};
      end else if (s_axi_araddr == PSTAT_OFF) begin
         rd_val = {25'h0, phy_rdy_s, oob_tx_burst, tx_sync_esc, 4'(tst_q)};
      end else if (s_axi_araddr == PMP_OFF) begin
         rd_val = {28'h0, pmp_q};
      end else if (s_axi_araddr == PCMD_OFF) begin
         rd_val = 32'h0000_0000;
      end else begin
         rd_ok  = 1'b0;
      end
   end

   // aw/w capture in either order; one write in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one cycle after address accept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // oob transmit and receive
   // ----------------------------------------------------------------
   logic [3:0] tx_burst_q;
   logic [3:0] tx_cyc_q;
   logic [3:0] rx_burst_q;
   logic [3:0] rx_gap_q;
   logic       oob_rx_d1_q;
   wire        oob_req  = cmd_rst || cmd_wake;
   wire        rx_rise  = oob_rx_s && !oob_rx_d1_q;
   wire        rx_seen  = rx_rise && (rx_burst_q == OOB_RX_BURSTS - 4'h1);

   // a new request restarts the count, so retries never go short
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ost_q        <= SAP_O_IDLE;
         tx_burst_q   <= 4'h0;
         tx_cyc_q     <= 4'h0;
         oob_tx_burst <= 1'b0;
      end else if (oob_req) begin
         ost_q        <= SAP_O_BURST;
         tx_burst_q   <= 4'h1;
         tx_cyc_q     <= 4'h0;
         oob_tx_burst <= 1'b1;
      end else begin
         tx_cyc_q <= tx_cyc_q + 4'h1;
         case (ost_q)
            SAP_O_IDLE: begin
               tx_cyc_q     <= 4'h0;
               oob_tx_burst <= 1'b0;
            end
            SAP_O_BURST: begin
               if (tx_cyc_q == OOB_BURST_CYC - 4'h1) begin
                  tx_cyc_q     <= 4'h0;
                  oob_tx_burst <= 1'b0;
                  ost_q        <= (tx_burst_q == OOB_TX_BURSTS) ? SAP_O_IDLE : SAP_O_GAP;
               end
            end
            SAP_O_GAP: begin
               if (tx_cyc_q == OOB_BURST_CYC - 4'h1) begin
                  tx_cyc_q     <= 4'h0;
                  tx_burst_q   <= tx_burst_q + 4'h1;
                  oob_tx_burst <= 1'b1;
                  ost_q        <= SAP_O_BURST;
               end
            end
            default: ost_q <= SAP_O_IDLE;
         endcase
      end
   end

   // receive: a long quiet spell breaks a burst run
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oob_rx_d1_q <= 1'b0;
         rx_burst_q  <= 4'h0;
         rx_gap_q    <= 4'h0;
      end else begin
         oob_rx_d1_q <= oob_rx_s;
         if (oob_rx_s) begin
            rx_gap_q <= 4'h0;
         end else if (rx_gap_q != 4'hF) begin
            rx_gap_q <= rx_gap_q + 4'h1;
         end
         if (rx_seen) begin
            rx_burst_q <= 4'h0;
         end else if (rx_rise) begin
            rx_burst_q <= rx_burst_q + 4'h1;
         end else if (rx_gap_q == 4'hF) begin
            rx_burst_q <= 4'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // receive transport and sync escape
   // ----------------------------------------------------------------
   logic  in_dmas_q;
   logic  in_data_q;
   logic  esc_pend_q;
   logic  phy_d1_q;
   wire   hdr_sdb  = rx_fis_type == FIS_SDB;
   wire   sdb_drop = hdr_sdb && rx_fis_nbit && (rx_fis_pmp != pmp_q);
   wire   phy_fall = phy_d1_q && !phy_rdy_s;
   wire   in_fis   = (tst_q == SAP_T_RX);
   wire   nd_loss  = phy_fall && in_fis && !in_data_q;
   wire   srst_hit = cmd_srst && in_fis && in_dmas_q;
   wire   esc_go   = esc_pend_q && rx_fis_start && (rx_fis_type == FIS_DATA);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tst_q        <= SAP_T_IDLE;
         in_dmas_q    <= 1'b0;
         in_data_q    <= 1'b0;
         esc_pend_q   <= 1'b0;
         rx_fis_store <= 1'b0;
         tx_sync_esc  <= 1'b0;
         phy_d1_q     <= 1'b0;
      end else begin
         phy_d1_q     <= phy_rdy_s;
         rx_fis_store <= 1'b0;
         if (srst_hit) begin
            esc_pend_q <= 1'b1;
         end
         case (tst_q)
            SAP_T_IDLE: begin
               tx_sync_esc <= 1'b0;
               if (esc_go) begin
                  tst_q       <= tx_xrdycoll ? SAP_T_ESC2 : SAP_T_ESC;
                  tx_sync_esc <= 1'b1;
                  esc_pend_q  <= 1'b0;
               end else if (rx_fis_start) begin
                  tst_q     <= SAP_T_RX;
                  in_dmas_q <= rx_fis_type == FIS_DMAS;
                  in_data_q <= rx_fis_type == FIS_DATA;
                  // n-bit sdb for another port is never stored
                  rx_fis_store <= !sdb_drop;
               end
            end
            SAP_T_RX: begin
               if (!phy_rdy_s || rx_fis_end) begin
                  tst_q <= SAP_T_IDLE;
               end
            end
            SAP_T_ESC, SAP_T_ESC2: begin
               tx_sync_esc <= 1'b1;
               tst_q       <= SAP_T_ESC_WAIT;
            end
            SAP_T_ESC_WAIT: begin
               tx_sync_esc <= !link_esc_done;
               if (link_esc_done) begin
                  tst_q <= SAP_T_IDLE;
               end
            end
            default: tst_q <= SAP_T_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // status, error and interrupt
   // ----------------------------------------------------------------
   logic [PIS_W-1:0] pis_set;
   assign pis_set[PIS_SDB_BIT]  = rx_fis_start && (tst_q == SAP_T_IDLE) && hdr_sdb
                                  && !sdb_drop && !esc_go;
   assign pis_set[PIS_PRCS_BIT] = phy_d1_q != phy_rdy_s;
   assign pis_set[PIS_INFS_BIT] = nd_loss;
   assign pis_set[PIS_OOB_BIT]  = rx_seen;

   wire   pend = |(pis_q & pie_q);

   // set wins over a same-cycle write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ghc_q  <= GHC_RST;
         pis_q  <= PIS_RST;
         pie_q  <= PIS_RST;
         serr_q <= 1'b0;
         pmp_q  <= PMP_RST;
         gis_q  <= 1'b0;
         irq    <= 1'b0;
      end else begin
         // phy loss raises only interface non-fatal and phy ready change, so the integrity bit stays untouched
         if (wr_serr && wdata_q[SERR_ERRI_BIT]) begin
            serr_q <= 1'b0;
         end
         if (host_rst) begin
            ghc_q <= GHC_RST;
            pis_q <= PIS_RST;
            pie_q <= PIS_RST;
            pmp_q <= PMP_RST;
            gis_q <= 1'b0;
            irq   <= 1'b0;
         end else begin
            if (wr_ghc) begin
               ghc_q <= {wdata_q[GHC_IE_BIT], 1'b0};
            end
            if (wr_pie) begin
               pie_q <= wdata_q[PIS_W-1:0];
            end
            if (wr_pmp) begin
               pmp_q <= wdata_q[3:0];
            end
            pis_q <= (pis_q & ~(wr_pis ? wdata_q[PIS_W-1:0] : PIS_RST)) | pis_set;
            // global bit is a registered copy of port pending state, one cycle late
            gis_q <= pend;
            irq   <= pend && gis_q && ghc_q[GHC_IE_BIT];
         end
      end
   end

endmodule : sap_port

/* design/sap_pkg.sv */
package sap_pkg;

   // register byte offsets
   localparam logic [7:0] GHC_OFF     = 8'h00;  // global control: hr, ie
   localparam logic [7:0] GIS_OFF     = 8'h04;  // global pending port bit
   localparam logic [7:0] PIS_OFF     = 8'h08;  // port interrupt status, w1c
   localparam logic [7:0] PIE_OFF     = 8'h0C;  // port interrupt mask
   localparam logic [7:0] SERR_OFF    = 8'h10;  // port error bits, w1c
   localparam logic [7:0] PCMD_OFF    = 8'h14;  // port command: oob, soft reset
   localparam logic [7:0] PSTAT_OFF   = 8'h18;  // port state readback
   localparam logic [7:0] PMP_OFF     = 8'h1C;  // current port multiplier port

   // field positions
   localparam int GHC_HR_BIT   = 0;
   localparam int GHC_IE_BIT   = 1;
   localparam int PIS_SDB_BIT  = 0;   // set device bits received
   localparam int PIS_PRCS_BIT = 1;   // phy ready change
   localparam int PIS_INFS_BIT = 2;   // interface non-fatal
   localparam int PIS_OOB_BIT  = 3;   // oob detected on receive
   localparam int SERR_ERRI_BIT = 0;  // recovered data integrity
   localparam int CMD_RST_BIT  = 0;   // send comreset
   localparam int CMD_WAKE_BIT = 1;   // send comwake
   localparam int CMD_SRST_BIT = 2;   // soft reset
   localparam int PIS_W        = 4;

   // reset values
   localparam logic [1:0]       GHC_RST = 2'h0;
   localparam logic [PIS_W-1:0] PIS_RST = 4'h0;
   localparam logic [3:0]       PMP_RST = 4'h0;

   // oob burst counts
   localparam logic [3:0] OOB_TX_BURSTS = 4'h6;
   localparam logic [3:0] OOB_RX_BURSTS = 4'h4;  // three gaps
   localparam logic [3:0] OOB_BURST_CYC = 4'hA;  // burst and gap length

   // fis types
   localparam logic [7:0] FIS_SDB   = 8'hA1;
   localparam logic [7:0] FIS_DMAS  = 8'h41;
   localparam logic [7:0] FIS_DATA  = 8'h46;

   // received fis header word and flags
   typedef struct packed {
      logic [3:0] pmp;
      logic       nbit;
      logic [7:0] fis_type;
   } sap_fis_hdr_type;

   typedef enum {
      SAP_T_IDLE,
      SAP_T_RX,
      SAP_T_ESC,
      SAP_T_ESC2,
      SAP_T_ESC_WAIT
   } sap_tstate_type;

   typedef enum {
      SAP_O_IDLE,
      SAP_O_BURST,
      SAP_O_GAP
   } sap_ostate_type;

endpackage : sap_pkg

/* design/sap_sync3.sv */
`timescale 1ns/1ps
// three-stage synchroniser; output changes once stages two and three agree
module sap_sync3
   import sap_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic d,
   output logic      q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q    <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q <= s3_q;
         end
      end
   end
endmodule : sap_sync3

/* verification/sap_port_sva.sv */
`timescale 1ns/1ps
// --------------------
// port checker
// --------------------
module sap_port_sva
   import sap_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       oob_tx_burst,
   input wire logic       rx_fis_start,
   input wire logic [7:0] rx_fis_type,
   input wire logic       rx_fis_store,
   input wire logic       tx_sync_esc,
   input wire logic       link_esc_done,
   input wire logic       irq,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic       prev_q;
   logic [4:0] hi_q;
   logic [4:0] lo_q;
   logic [3:0] nb_q;

   // burst shape; lo saturates on idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= 1'b0;
         hi_q   <= 5'h00;
         lo_q   <= 5'h1F;
         nb_q   <= 4'h0;
      end else begin
         prev_q <= oob_tx_burst;
         hi_q   <= oob_tx_burst ? hi_q + 5'h01 : 5'h00;
         lo_q   <= oob_tx_burst ? 5'h00 : ((lo_q == 5'h1F) ? lo_q : lo_q + 5'h01);
         if (oob_tx_burst && !prev_q)
            nb_q <= nb_q + 4'h1;
         else if (lo_q == 5'h0B)
            nb_q <= 4'h0;
      end
   end

   a_burst_len: assert property (prev_q && !oob_tx_burst |-> hi_q == 5'h0A)
      else $error("burst length not ten cycles");
   a_burst_gap: assert property (oob_tx_burst && !prev_q && nb_q != 4'h0 |-> lo_q == 5'h0A)
      else $error("gap length not ten cycles");
   a_six_bursts: assert property (lo_q == 5'h0B |-> nb_q == 4'h0 || nb_q == 4'h6)
      else $error("oob train not six bursts");
   a_store_cause: assert property (rx_fis_store |-> $past(rx_fis_start))
      else $error("store without fis start");
   a_esc_cause: assert property ($rose(tx_sync_esc) |-> $past(rx_fis_type) == FIS_DATA)
      else $error("escape without data fis");
   a_esc_hold: assert property (tx_sync_esc && !link_esc_done |=> tx_sync_esc)
      else $error("escape dropped early");
   a_esc_drop: assert property (tx_sync_esc && link_esc_done |=> !tx_sync_esc)
      else $error("escape held after done");
   a_irq_reset: assert property ($rose(aresetn) |-> !irq ##1 !irq)
      else $error("irq after reset");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");

   c_six: cover property (nb_q == 4'h6);
   c_esc: cover property ($rose(tx_sync_esc));
   c_store: cover property (rx_fis_store);
   c_irq: cover property (irq);
endmodule : sap_port_sva

/* verification/sap_dev_model.sv */
`timescale 1ns/1ps
// --------------------
// attached drive and link model
// --------------------
module sap_dev_model
   import sap_pkg::*;
(
   input  wire logic aclk,
   input  wire logic tx_sync_esc,
   output logic       phy_rdy = 1'b1,
   output logic       oob_rx_burst = 1'b0,
   output logic       rx_fis_start = 1'b0,
   output logic [7:0] rx_fis_type = 8'h00,
   output logic       rx_fis_nbit = 1'b0,
   output logic [3:0] rx_fis_pmp = 4'h0,
   output logic       rx_fis_end = 1'b0,
   output logic       tx_xrdycoll = 1'b0,
   output logic       link_esc_done = 1'b0
);
   int esc_delay = 4;  // escape latency
   int wait_q    = 0;

   // bursts and gaps of ten, inside the gap window
   task automatic send_oob(input int n);
      repeat (n) begin
         @(posedge aclk);
         oob_rx_burst <= 1'b1;
         repeat (10) @(posedge aclk);
         oob_rx_burst <= 1'b0;
         repeat (9) @(posedge aclk);
      end
   endtask : send_oob

   // header valid only with start, garbage after
   task automatic fis_begin(input logic [7:0] t, input logic n, input logic [3:0] p);
      @(posedge aclk);
      rx_fis_start <= 1'b1;
      rx_fis_type  <= t;
      rx_fis_nbit  <= n;
      rx_fis_pmp   <= p;
      @(posedge aclk);
      rx_fis_start <= 1'b0;
      rx_fis_type  <= ~t;
      rx_fis_nbit  <= ~n;
      rx_fis_pmp   <= ~p;
   endtask : fis_begin

   task automatic fis_finish();
      @(posedge aclk);
      rx_fis_end <= 1'b1;
      @(posedge aclk);
      rx_fis_end <= 1'b0;
   endtask : fis_finish

   task automatic set_phy(input logic v);
      @(posedge aclk);
      phy_rdy <= v;
   endtask : set_phy

   task automatic set_coll(input logic v);
      @(posedge aclk);
      tx_xrdycoll <= v;
   endtask : set_coll

   // link ends an escape after esc_delay
   always @(posedge aclk) begin
      link_esc_done <= 1'b0;
      if (tx_sync_esc && !link_esc_done && wait_q >= esc_delay) begin
         link_esc_done <= 1'b1;
         wait_q        <= 0;
      end else if (tx_sync_esc && !link_esc_done) begin
         wait_q <= wait_q + 1;
      end
   end
endmodule : sap_dev_model

/* verification/test_sap_port.sv */
`timescale 1ns/1ps
// --------------------
// port testbench
// --------------------
module test_sap_port;
   import sap_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        phy_rdy, oob_rx_burst, oob_tx_burst, rx_fis_start, rx_fis_nbit, rx_fis_end;
   logic [7:0]  rx_fis_type;
   logic [3:0]  rx_fis_pmp, s_axi_wstrb = 4'hF;
   logic        rx_fis_store, tx_sync_esc, tx_xrdycoll, link_esc_done, irq;
   logic        prev_tx = 1'b0, prev_esc = 1'b0;
   int          fail_count = 0, compares = 0, tx_rises = 0, stores = 0, escs = 0, base;
   logic [7:0]  ft [3] = '{FIS_SDB, FIS_SDB, FIS_SDB};
   logic [3:0]  fp [3] = '{4'h3, 4'h2, 4'h5};
   logic        fn [3] = '{1'b1, 1'b1, 1'b0};
   logic        fe [3] = '{1'b0, 1'b1, 1'b1};

   always #2 aclk = ~aclk;

   sap_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .phy_rdy(phy_rdy),
      .oob_rx_burst(oob_rx_burst), .oob_tx_burst(oob_tx_burst), .rx_fis_start(rx_fis_start),
      .rx_fis_type(rx_fis_type), .rx_fis_nbit(rx_fis_nbit), .rx_fis_pmp(rx_fis_pmp),
      .rx_fis_end(rx_fis_end), .rx_fis_store(rx_fis_store), .tx_sync_esc(tx_sync_esc),
      .tx_xrdycoll(tx_xrdycoll), .link_esc_done(link_esc_done), .irq(irq));

   sap_dev_model dev_u (.aclk(aclk), .tx_sync_esc(tx_sync_esc), .phy_rdy(phy_rdy),
      .oob_rx_burst(oob_rx_burst), .rx_fis_start(rx_fis_start), .rx_fis_type(rx_fis_type),
      .rx_fis_nbit(rx_fis_nbit), .rx_fis_pmp(rx_fis_pmp), .rx_fis_end(rx_fis_end),
      .tx_xrdycoll(tx_xrdycoll), .link_esc_done(link_esc_done));

   // pulse counters
   always @(posedge aclk) begin
      prev_tx  <= oob_tx_burst;
      prev_esc <= tx_sync_esc;
      if (oob_tx_burst === 1'b1 && !prev_tx) tx_rises++;
      if (tx_sync_esc === 1'b1 && !prev_esc) escs++;
      if (rx_fis_store === 1'b1) stores++;
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // aw and w offered together, each dropped once taken; strobes are ignored
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= a[3:0] | 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m,
                     input logic [31:0] e, input string n);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      chk(n, e, s_axi_rdata & m);
   endtask : rd

   // watchdog, run needs under 2000 cycles
   initial begin
      repeat (8000) @(posedge aclk);
      fail_count++;
      $display("CHECK FAILED watchdog expected done seen hang");
      conclude();
   end

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(GHC_OFF, 2'h0, 32'h3, 32'h0, "ghc");
      rd(8'h40, 2'h2, 32'hFFFFFFFF, 32'h0, "unmapped");
      wr(8'h44, 32'h1, 2'h2);
      wr(PIS_OFF, 32'hF, 2'h0);
      // comreset then comwake, each train left to finish before the next
      for (int i = 0; i < 2; i++) begin
         base = tx_rises;
         wr(PCMD_OFF, 32'h1 << i, 2'h0);
         repeat (150) @(posedge aclk);
         chk("bursts", 32'h6, tx_rises - base);
      end
      dev_u.send_oob(3);
      repeat (40) @(posedge aclk);
      rd(PIS_OFF, 2'h0, 32'h8, 32'h0, "oob3");
      dev_u.send_oob(4);
      repeat (40) @(posedge aclk);
      rd(PIS_OFF, 2'h0, 32'h8, 32'h8, "oob4");
      wr(PMP_OFF, 32'h2, 2'h0);
      for (int i = 0; i < 3; i++) begin
         wr(PIS_OFF, 32'hF, 2'h0);
         base = stores;
         dev_u.fis_begin(ft[i], fn[i], fp[i]);
         dev_u.fis_finish();
         repeat (4) @(posedge aclk);
         chk("store", 32'(fe[i]), stores - base);
         rd(PIS_OFF, 2'h0, 32'h1, 32'(fe[i]), "sdb");
      end
      // srst in dma setup; pass two adds collision, slow link
      for (int i = 0; i < 2; i++) begin
         dev_u.set_coll(i[0]);
         dev_u.esc_delay = 3 + 12 * i;
         base = escs;
         dev_u.fis_begin(FIS_DMAS, 1'b0, 4'h0);
         wr(PCMD_OFF, 32'h4, 2'h0);
         dev_u.fis_finish();
         dev_u.fis_begin(FIS_DATA, 1'b0, 4'h0);
         repeat (30) @(posedge aclk);
         chk("escape", 32'h1, escs - base);
         chk("esc_idle", 32'h0, 32'(tx_sync_esc));
         dev_u.fis_finish();
      end
      dev_u.set_coll(1'b0);
      wr(PIS_OFF, 32'hF, 2'h0);
      wr(SERR_OFF, 32'h1, 2'h0);
      dev_u.fis_begin(FIS_SDB, 1'b0, 4'h2);
      dev_u.set_phy(1'b0);
      repeat (10) @(posedge aclk);
      dev_u.fis_finish();
      rd(PIS_OFF, 2'h0, 32'h6, 32'h6, "infs_prcs");
      rd(SERR_OFF, 2'h0, 32'h1, 32'h0, "erri");
      dev_u.set_phy(1'b1);
      // gating, mask, host reset with status set
      wr(PIE_OFF, 32'hF, 2'h0);
      repeat (4) @(posedge aclk);
      chk("irq_off", 32'h0, 32'(irq));
      wr(GHC_OFF, 32'h2, 2'h0);
      repeat (4) @(posedge aclk);
      chk("irq_on", 32'h1, 32'(irq));
      rd(GIS_OFF, 2'h0, 32'h1, 32'h1, "gis");
      wr(PIE_OFF, 32'h0, 2'h0);
      repeat (4) @(posedge aclk);
      chk("irq_mask", 32'h0, 32'(irq));
      wr(PIE_OFF, 32'hF, 2'h0);
      wr(GHC_OFF, 32'h3, 2'h0);
      rd(GIS_OFF, 2'h0, 32'h1, 32'h0, "gis_hr");
      rd(GHC_OFF, 2'h0, 32'h3, 32'h0, "ghc_hr");
      wr(GHC_OFF, 32'h2, 2'h0);
      repeat (4) @(posedge aclk);
      chk("irq_stale", 32'h0, 32'(irq));
      wr(PIE_OFF, 32'hF, 2'h0);
      dev_u.set_phy(1'b0);
      repeat (12) @(posedge aclk);
      chk("irq_event", 32'h1, 32'(irq));
      wr(PIS_OFF, 32'hF, 2'h0);
      repeat (4) @(posedge aclk);
      chk("irq_clear", 32'h0, 32'(irq));
      conclude();
   end
endmodule : test_sap_port

bind sap_port sap_port_sva chk_u (.aclk(aclk), .aresetn(aresetn),
   .oob_tx_burst(oob_tx_burst), .rx_fis_start(rx_fis_start), .rx_fis_type(rx_fis_type),
   .rx_fis_store(rx_fis_store), .tx_sync_esc(tx_sync_esc), .link_esc_done(link_esc_done),
   .irq(irq), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
